// >>> logic/sld_regs.svh
// Constants for the squib loop diagnostic result status register.
// Assumes inclusion by bare name from package and design files.
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH

// ----------------------------------------
// Address and widths
// ----------------------------------------
`define SLD_ADDR_W 7
`define SLD_ADDR_STATUS 7'h37
`define SLD_WORD_W 20
`define SLD_STORE_W 24
`define SLD_NIB_W 4
`define SLD_WORD_RESET 20'h0_0000
`define SLD_STORE_RESET 24'h00_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SLD_BIT_DEPTH 19
`define SLD_BIT_RUNNING 18
`define SLD_BIT_PRIOR 16
`define SLD_BIT_FET 15
`define SLD_BIT_OVER 13
`define SLD_BIT_UNDER 12
`define SLD_RES_CH_LSB 8
`define SLD_BIT_L2L 7
`define SLD_BIT_GND 6
`define SLD_BIT_BAT 5
`define SLD_LEAK_CH_LSB 0
`define SLD_CODE_LSB 20

// ----------------------------------------
// Upper diagnostic test codes
// ----------------------------------------
`define SLD_CODE_NONE 4'h0
`define SLD_CODE_CMV 4'h1
`define SLD_CODE_LEAK 4'h2
`define SLD_CODE_L2L 4'h3
`define SLD_CODE_RANGE 4'h5
`define SLD_CODE_RMEAS 4'h6
`define SLD_CODE_FET 4'h7
`define SLD_CH_LAST 4'h3

`endif

// >>> logic/sld_pkg.sv
// Types shared by the loop diagnostic status block.
// Assumes sld_regs.svh is on the include path.
`include "sld_regs.svh"

package sld_pkg;

  typedef logic [`SLD_NIB_W-1:0] sld_nib_t;
  typedef logic [`SLD_ADDR_W-1:0] sld_addr_t;
  typedef logic [`SLD_WORD_W-1:0] sld_word_t;
  typedef logic [`SLD_STORE_W-1:0] sld_store_t;

  typedef enum logic [`SLD_NIB_W-1:0] {
    SLD_DIAGNOSTIC_STATE_NONE = `SLD_CODE_NONE,
    SLD_DIAGNOSTIC_STATE_CMV = `SLD_CODE_CMV,
    SLD_DIAGNOSTIC_STATE_LEAK = `SLD_CODE_LEAK,
    SLD_DIAGNOSTIC_STATE_L2L = `SLD_CODE_L2L,
    SLD_DIAGNOSTIC_STATE_RANGE = `SLD_CODE_RANGE,
    SLD_DIAGNOSTIC_STATE_RMEAS = `SLD_CODE_RMEAS,
    SLD_DIAGNOSTIC_STATE_FET = `SLD_CODE_FET
  } sld_diagnostic_state_code_t;

  typedef struct packed {
    sld_word_t rd_data;
    logic rd_valid;
    logic rd_hit;
    logic running;
  } sld_rd_state_t;

endpackage : sld_pkg

// >>> logic/sld_fld_if.sv
// Update lanes between the status control and its field store.
// Assumes both ends run on the same clock.
interface sld_fld_if #(parameter int W = 24);
  logic clr;
  logic [W-1:0] ld_a;
  logic [W-1:0] d_a;
  logic [W-1:0] ld_b;
  logic [W-1:0] d_b;
  logic [W-1:0] q;

  modport store (input clr, input ld_a, input d_a, input ld_b, input d_b, output q);
  modport ctrl (output clr, output ld_a, output d_a, output ld_b, output d_b, input q);
endinterface : sld_fld_if

// >>> logic/sld_status_store.sv
// Per-bit field store with two load layers and a clear.
// Assumes load masks come from logic on the same clock.
module sld_status_store #(parameter int W = 24)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Update lanes
  sld_fld_if.store fld
);

  typedef struct packed {
    logic [W-1:0] q;
  } sld_store_state_t;

  sld_store_state_t s_reg;
  sld_store_state_t s_next;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Field events beat the loop machine, and both beat the clear,
  // so an event landing with a safing reset is never lost.
  always_comb
  begin
    s_next = s_reg;
    for (int i = 0; i < W; i++)
    begin
      if (fld.ld_b[i])
      begin
        s_next.q[i] = fld.d_b[i];
      end
      else if (fld.ld_a[i])
      begin
        s_next.q[i] = fld.d_a[i];
      end
      else if (fld.clr)
      begin
        s_next.q[i] = 1'h0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign fld.q = s_reg.q;

endmodule : sld_status_store

// >>> logic/sld_loop_diagnostic_state_status.sv
// Loop diagnostic result status register and its read port.
// Assumes an SPI frame decoder on the same clock delivers decoded frames.
`include "sld_regs.svh"

module sld_loop_diagnostic_state_status
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Decoded SPI frame
  input wire logic frame_valid,
  input wire sld_pkg::sld_addr_t frame_addr,
  input wire logic frame_write,
  input wire sld_pkg::sld_word_t frame_data,
  // Request register write
  input wire logic req_write,
  input wire logic req_depth,
  // Safing machine
  input wire logic safing_machine_reset,
  // Loop diagnostic machine
  input wire logic test_running_flag,
  input wire logic lds_update,
  input wire logic lds_prior_fault,
  input wire logic lds_switch_on,
  input wire logic lds_over,
  input wire logic lds_under,
  input wire sld_pkg::sld_nib_t lds_res_ch,
  input wire sld_pkg::sld_nib_t lds_code,
  input wire logic lds_l2l,
  input wire logic lds_gnd,
  input wire logic lds_bat,
  input wire sld_pkg::sld_nib_t lds_leak_ch,
  // Field events
  input wire logic diagnostic_state,
  input wire logic switch_on_evt,
  input wire logic rtest_done,
  input wire logic rtest_over,
  input wire logic rtest_under,
  input wire logic res_ch_update,
  input wire sld_pkg::sld_nib_t res_ch,
  input wire logic leak_done,
  input wire logic leak_gnd,
  input wire logic leak_bat,
  input wire sld_pkg::sld_nib_t leak_ch,
  // Read answer
  output sld_pkg::sld_word_t rd_data_reg,
  output logic rd_valid_reg,
  output logic rd_hit_reg
);
  import sld_pkg::*;

  sld_fld_if #(.W(`SLD_STORE_W)) fld ();
  sld_rd_state_t s_reg;
  sld_rd_state_t s_next;
  sld_store_t mask_a;
  sld_store_t dat_a;
  sld_store_t mask_b;
  sld_store_t dat_b;
  sld_word_t word;
  logic hit;
  logic any_evt;

  sld_status_store #(.W(`SLD_STORE_W)) u_store
  (
    .clk(clk),
    .srst(srst),
    .fld(fld)
  );

  // ----------------------------------------
  // Field update lanes
  // ----------------------------------------
  always_comb
  begin
    mask_a = '0;
    dat_a = '0;
    mask_b = '0;
    dat_b = '0;
    mask_a[`SLD_BIT_DEPTH] = req_write;
    dat_a[`SLD_BIT_DEPTH] = req_depth;
    if (lds_update)
    begin
      mask_a[`SLD_BIT_PRIOR] = 1'h1;
      dat_a[`SLD_BIT_PRIOR] = lds_prior_fault;
      mask_a[`SLD_BIT_FET] = 1'h1;
      dat_a[`SLD_BIT_FET] = lds_switch_on;
      mask_a[`SLD_BIT_OVER] = 1'h1;
      dat_a[`SLD_BIT_OVER] = lds_over;
      mask_a[`SLD_BIT_UNDER] = 1'h1;
      dat_a[`SLD_BIT_UNDER] = lds_under;
      mask_a[`SLD_RES_CH_LSB +: `SLD_NIB_W] = '1;
      dat_a[`SLD_RES_CH_LSB +: `SLD_NIB_W] = lds_res_ch;
      mask_a[`SLD_CODE_LSB +: `SLD_NIB_W] = '1;
      dat_a[`SLD_CODE_LSB +: `SLD_NIB_W] = lds_code;
      mask_a[`SLD_BIT_L2L] = 1'h1;
      dat_a[`SLD_BIT_L2L] = lds_l2l;
      mask_a[`SLD_BIT_GND] = 1'h1;
      dat_a[`SLD_BIT_GND] = lds_gnd;
      mask_a[`SLD_BIT_BAT] = 1'h1;
      dat_a[`SLD_BIT_BAT] = lds_bat;
      mask_a[`SLD_LEAK_CH_LSB +: `SLD_NIB_W] = '1;
      dat_a[`SLD_LEAK_CH_LSB +: `SLD_NIB_W] = lds_leak_ch;
    end
    mask_b[`SLD_BIT_FET] = switch_on_evt & diagnostic_state;
    dat_b[`SLD_BIT_FET] = 1'h1;
    mask_b[`SLD_BIT_OVER] = rtest_done;
    dat_b[`SLD_BIT_OVER] = rtest_over;
    mask_b[`SLD_BIT_UNDER] = rtest_done;
    dat_b[`SLD_BIT_UNDER] = rtest_under;
    mask_b[`SLD_RES_CH_LSB +: `SLD_NIB_W] = {`SLD_NIB_W{res_ch_update}};
    dat_b[`SLD_RES_CH_LSB +: `SLD_NIB_W] = res_ch;
    mask_b[`SLD_BIT_GND] = leak_done;
    dat_b[`SLD_BIT_GND] = leak_gnd;
    mask_b[`SLD_BIT_BAT] = leak_done;
    dat_b[`SLD_BIT_BAT] = leak_bat;
    mask_b[`SLD_LEAK_CH_LSB +: `SLD_NIB_W] = {`SLD_NIB_W{leak_done}};
    dat_b[`SLD_LEAK_CH_LSB +: `SLD_NIB_W] = leak_ch;
  end

  assign fld.clr = safing_machine_reset;
  assign fld.ld_a = mask_a;
  assign fld.d_a = dat_a;
  assign fld.ld_b = mask_b;
  assign fld.d_b = dat_b;
  assign any_evt = (|mask_a) | (|mask_b);

  // ----------------------------------------
  // Read word and answer
  // ----------------------------------------
  // Channel and code share bits 11:8; depth picks which one shows.
  always_comb
  begin
    word = fld.q[`SLD_WORD_W-1:0];
    word[`SLD_BIT_RUNNING] = s_reg.running;
    if (fld.q[`SLD_BIT_DEPTH])
    begin
      word[`SLD_RES_CH_LSB +: `SLD_NIB_W] = fld.q[`SLD_CODE_LSB +: `SLD_NIB_W];
    end
  end

  assign hit = frame_valid && (frame_addr == `SLD_ADDR_STATUS);

  // Write frames read back too; their data bits never reach the store.
  always_comb
  begin
    s_next = s_reg;
    s_next.running = test_running_flag;
    s_next.rd_valid = frame_valid;
    s_next.rd_hit = hit;
    s_next.rd_data = hit ? word : `SLD_WORD_RESET;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign rd_data_reg = s_reg.rd_data;
  assign rd_valid_reg = s_reg.rd_valid;
  assign rd_hit_reg = s_reg.rd_hit;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence status_read_s;
    hit && !fld.q[`SLD_BIT_DEPTH];
  endsequence

  sequence upper_read_s;
    hit && fld.q[`SLD_BIT_DEPTH];
  endsequence

  // Switch event, a quiet cycle, then a read of the stored flag
  sequence switch_seen_s;
    switch_on_evt && diagnostic_state ##1 !safing_machine_reset && !lds_update ##1 hit;
  endsequence

  depth_follows_a: assert property (req_write |=> fld.q[`SLD_BIT_DEPTH] == $past(req_depth))
    else $error("depth bit not refreshed by request write");
  prior_fault_a: assert property (lds_update |=> fld.q[`SLD_BIT_PRIOR] == $past(lds_prior_fault))
    else $error("prior fault flag not loaded");
  switch_on_a: assert property (switch_seen_s |=> rd_data_reg[`SLD_BIT_FET])
    else $error("switch on flag missing from read");
  switch_set_a: assert property (switch_on_evt && diagnostic_state |=> fld.q[`SLD_BIT_FET])
    else $error("switch on flag not set");
  range_over_a: assert property (rtest_done |=> fld.q[`SLD_BIT_OVER] == $past(rtest_over))
    else $error("over range flag wrong");
  range_under_a: assert property (rtest_done |=> fld.q[`SLD_BIT_UNDER] == $past(rtest_under))
    else $error("under range flag wrong");
  res_chan_read_a: assert property (status_read_s |=> rd_valid_reg && rd_hit_reg && rd_data_reg[`SLD_RES_CH_LSB +: `SLD_NIB_W] == $past(fld.q[`SLD_RES_CH_LSB +: `SLD_NIB_W]))
    else $error("resistance channel read wrong");
  upper_code_read_a: assert property (upper_read_s |=> rd_data_reg[`SLD_RES_CH_LSB +: `SLD_NIB_W] == $past(fld.q[`SLD_CODE_LSB +: `SLD_NIB_W]))
    else $error("upper diagnostic code read wrong");
  safing_clear_a: assert property (safing_machine_reset && !any_evt |=> fld.q == `SLD_STORE_RESET)
    else $error("safing reset left a field set");
  short_flags_a: assert property (lds_update && !leak_done |=> fld.q[`SLD_BIT_L2L:`SLD_BIT_BAT] == $past({lds_l2l, lds_gnd, lds_bat}))
    else $error("short flags not loaded");
  leak_chan_a: assert property (leak_done |=> fld.q[`SLD_LEAK_CH_LSB +: `SLD_NIB_W] == $past(leak_ch))
    else $error("leakage channel not loaded");
  read_only_a: assert property (frame_valid && !any_evt && !safing_machine_reset |=> $stable(fld.q))
    else $error("frame altered the result fields");

endmodule : sld_loop_diagnostic_state_status

// >>> tb/sld_host_model.sv
// Host side model: issues decoded register frames to the status block.
// Assumes the bench raises req for one clock per frame, changed after an edge.
module sld_host_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bench request
  input wire logic req,
  input wire sld_pkg::sld_addr_t req_addr,
  input wire logic req_wr,
  input wire sld_pkg::sld_word_t req_data,
  // Decoded frame
  output logic frame_valid,
  output sld_pkg::sld_addr_t frame_addr,
  output logic frame_write,
  output sld_pkg::sld_word_t frame_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import sld_pkg::*;
  // Idle lines churn so a stale value can never pass for a frame
  sld_word_t noise_reg;
  always_ff @(posedge clk)
  begin
    noise_reg <= srst ? 20'h5_A5A5 : ~noise_reg + 20'h0_0001;
  end
  assign frame_valid = req;
  assign frame_addr = req ? req_addr : noise_reg[6:0];
  assign frame_write = req ? req_wr : noise_reg[0];
  assign frame_data = req ? req_data : noise_reg;
endmodule : sld_host_model

// >>> tb/sld_loop_diagnostic_state_status_tb.sv
// Self-checking bench for the loop diagnostic result status register.
// Assumes the host model delivers frames; all other inputs come from here.
module sld_loop_diagnostic_state_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sld_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req = 1'b0, rw = 1'b0, req_depth = 1'b0, run_flag = 1'b0, dstate = 1'b0;
  sld_addr_t ra = 7'h00;
  sld_word_t rdat = 20'h0_0000, rd_data_reg;
  logic [6:0] ev = 7'h00;
  logic p_f = 1'b0, p_s = 1'b0, p_o = 1'b0, p_u = 1'b0, p_l = 1'b0, p_g = 1'b0, p_b = 1'b0;
  logic r_o = 1'b0, r_u = 1'b0, k_g = 1'b0, k_b = 1'b0;
  sld_nib_t l_rc = 4'h0, l_cd = 4'h0, l_lk = 4'h0, rch = 4'h0, kch = 4'h0;
  sld_nib_t l_cd_tab[6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
  logic fv, fw, rd_valid_reg, rd_hit_reg;
  sld_addr_t fa;
  sld_word_t fd;
  int miscompares = 0;
  int checks = 0;
  always #5 clk = ~clk;
  sld_host_model host (.clk(clk), .srst(srst), .req(req), .req_addr(ra), .req_wr(rw),
    .req_data(rdat), .frame_valid(fv), .frame_addr(fa), .frame_write(fw), .frame_data(fd));
  sld_loop_diagnostic_state_status uut (.clk(clk), .srst(srst), .frame_valid(fv), .frame_addr(fa),
    .frame_write(fw), .frame_data(fd), .req_write(ev[6]), .req_depth(req_depth),
    .safing_machine_reset(ev[0]), .test_running_flag(run_flag), .lds_update(ev[5]),
    .lds_prior_fault(p_f), .lds_switch_on(p_s), .lds_over(p_o), .lds_under(p_u),
    .lds_res_ch(l_rc), .lds_code(l_cd), .lds_l2l(p_l), .lds_gnd(p_g), .lds_bat(p_b),
    .lds_leak_ch(l_lk), .diagnostic_state(dstate), .switch_on_evt(ev[4]),
    .rtest_done(ev[3]), .rtest_over(r_o), .rtest_under(r_u), .res_ch_update(ev[2]),
    .res_ch(rch), .leak_done(ev[1]), .leak_gnd(k_g), .leak_bat(k_b), .leak_ch(kch),
    .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg), .rd_hit_reg(rd_hit_reg));
  // ----------------------------------------
  // Compare, event and read tasks
  // ----------------------------------------
  task automatic chk_word(input sld_word_t got, input sld_word_t exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  // Order: request, update, switch, rtest, res channel, leak, safing reset
  task automatic fire(input logic [6:0] e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= 7'h00;
  endtask : fire
  task automatic rd(input sld_addr_t a, input logic w, input sld_word_t d,
    input logic hit, input sld_word_t exp);
    @(posedge clk);
    req <= 1'b1;
    ra <= a;
    rw <= w;
    rdat <= d;
    @(posedge clk) req <= 1'b0;
    #1;
    chk_bit(rd_valid_reg, 1'b1, "valid");
    chk_bit(rd_hit_reg, hit, "hit");
    chk_word(rd_data_reg, exp, "word");
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h0_0000);
    rd(7'h36, 1'b0, 20'h0_0000, 1'b0, 20'h0_0000);
    req_depth <= 1'b1;
    l_rc <= 4'h2;
    fire(7'h40);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h8_0000);
    foreach (l_cd_tab[i])
    begin
      l_cd <= l_cd_tab[i];
      fire(7'h20);
      rd(7'h37, 1'b0, 20'h0_0000, 1'b1, {8'h80, l_cd_tab[i], 8'h00});
    end
    $display("test depth and codes done");
    req_depth <= 1'b0;
    fire(7'h40);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h0_0200);
    {p_f, p_o, p_l, p_g, p_b} <= 5'h1F;
    {l_rc, l_lk} <= 8'h33;
    fire(7'h20);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h1_23E3);
    // Switch event outside the diagnostic state must not stick
    fire(7'h10);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h1_23E3);
    dstate <= 1'b1;
    fire(7'h10);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h1_A3E3);
    {r_o, r_u} <= 2'b01;
    fire(7'h08);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h1_93E3);
    rch <= 4'hF;
    fire(7'h04);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h1_9FE3);
    {k_g, k_b, kch} <= 6'h1A;
    fire(7'h02);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h1_9FAA);
    $display("test field events done");
    rd(7'h37, 1'b1, 20'hF_FFFF, 1'b1, 20'h1_9FAA);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h1_9FAA);
    rd(7'h36, 1'b1, 20'hF_FFFF, 1'b0, 20'h0_0000);
    $display("test write frames done");
    run_flag <= 1'b1;
    fire(7'h01);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h4_0000);
    {r_o, r_u} <= 2'b10;
    fire(7'h09);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h4_2000);
    {p_f, p_s, p_o, p_u, p_l, p_g, p_b} <= 7'h28;
    fire(7'h20);
    rd(7'h37, 1'b0, 20'h0_0000, 1'b1, 20'h4_9303);
    $display("test safing reset done");
    end_of_test();
  end
  // Whole run is under a hundred cycles; this is a generous ceiling
  initial
  begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule : sld_loop_diagnostic_state_status_tb
